// ### logic/rlcf_pkg.sv
// Shared constants, types and helpers of the radio line coder and framer.
// Assumes a single 200 MHz clock shared by every module that imports nothing.
package rlcf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int CHIP_NS = 100;
  localparam int CHIP_CYC = (CHIP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] CHIP_LAST = 5'(CHIP_CYC - 1);
  localparam logic [4:0] CHIP_HALF = 5'(CHIP_CYC / 2);

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PRE_BYTE = 8'hAA;
  localparam logic [3:0] PRE_DEF = 4'h4;
  localparam logic [11:0] START_PAT = 12'hB2D;
  localparam logic [4:0] START_LEN = 5'h0C;
  localparam logic [4:0] RAW_CHIPS = 5'h08;
  localparam logic [4:0] MAN_CHIPS = 5'h10;
  localparam logic [4:0] SYM_CHIPS = 5'h0C;
  localparam logic [3:0] HDR_LAST = 4'h3;
  localparam logic [3:0] RX_MSG = 4'h4;
  localparam logic [3:0] RX_CRC_HI = 4'h5;
  localparam logic [3:0] RX_CRC_LO = 4'h6;
  localparam logic [7:0] BCAST8 = 8'hFF;
  localparam logic [3:0] BCAST4 = 4'hF;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [2:0] RUN_MAX = 3'h7;

  // ----------------------------------------------------------------
  // Frame check field
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  // Half-symbol table: three ones each, no end run over two
  localparam logic [15:0][5:0] SYM_TAB = {
    6'h34, 6'h32, 6'h31, 6'h2C, 6'h29, 6'h26, 6'h25, 6'h23,
    6'h1C, 6'h1A, 6'h19, 6'h16, 6'h13, 6'h0E, 6'h0D, 6'h0B};

  typedef enum logic [2:0] {T_IDLE, T_PRE, T_START, T_HDR, T_MSG, T_CRC, T_FIN} rlcf_tx_st_t;
  typedef enum logic [1:0] {R_HUNT, R_DATA} rlcf_rx_st_t;

  // One byte through the reflected frame check, low bit first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ### logic/rlcf_symtab.sv
// Byte to twelve-bit balanced symbol coder and its inverse.
// Assumes the caller holds inputs stable for one clock; clock feeds checks only.
module rlcf_symtab (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] enc_byte_in,
  output logic [11:0] enc_word_out,
  input wire logic [11:0] dec_word_in,
  output logic [7:0] dec_byte_out,
  output logic dec_err_out
);

  // Reverse lookup, flags a code with no table entry
  function automatic logic [4:0] code2nib(input logic [5:0] code);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (rlcf_pkg::SYM_TAB[i] == code) begin
        r = {1'b0, 4'(i)};
      end
    end
    return r;
  endfunction

  logic [4:0] dec_hi;
  logic [4:0] dec_lo;

  // Two nibble lookups per direction
  assign enc_word_out = {rlcf_pkg::SYM_TAB[enc_byte_in[7:4]], rlcf_pkg::SYM_TAB[enc_byte_in[3:0]]};
  assign dec_hi = code2nib(dec_word_in[11:6]);
  assign dec_lo = code2nib(dec_word_in[5:0]);
  assign dec_byte_out = {dec_hi[3:0], dec_lo[3:0]};
  assign dec_err_out = dec_hi[4] | dec_lo[4];

  a_word_balance: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $countones(enc_word_out) == 6) else $error("symbol word not balanced");

  a_table_inverse: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    {code2nib(enc_word_out[11:6]), code2nib(enc_word_out[5:0])} == {1'b0, enc_byte_in[7:4],
    1'b0, enc_byte_in[3:0]}) else $error("half-symbol table not invertible");

endmodule

// ### logic/rlcf_top.sv
// Line coder and packet framer for an on-off-keyed radio front end.
// Assumes chip-aligned receive data at the transmit chip rate and one clock.

// How it works
// - Manchester: one sends high-low, zero low-high
// - Manchester chip runs never exceed two
// - Symbol words carry six ones, six zeros
// - Two table half-symbols per byte, inverse decode
// - Symbol stream runs never exceed four bits
// - Packet opens with alternating preamble bytes
// - Preamble length configurable, default four bytes
// - Fixed field order through check field bytes
// - Twelve-bit start pattern marks packet body
// - Trailing bytes carry frame check value
// - Receiver recomputes and compares check value
// - Four or eight bit addresses, broadcast
module rlcf_top (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic mode_sel_in,
  input wire logic addr_wide_in,
  input wire logic [3:0] preamble_len_in,
  input wire logic [7:0] local_addr_in,
  input wire logic tx_start_in,
  input wire logic [7:0] tx_dst_in,
  input wire logic [7:0] tx_src_in,
  input wire logic [7:0] tx_num_in,
  input wire logic [7:0] tx_size_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic tx_chip_out,
  output logic tx_busy_out,
  output logic tx_done_out,
  output logic tx_underrun_out,
  input wire logic rx_chip_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_busy_out,
  output logic rx_done_out,
  output logic rx_crc_ok_out,
  output logic rx_code_err_out,
  output logic rx_addr_ok_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rlcf_pkg::rlcf_tx_st_t tst;
    logic tmode;
    logic [3:0] pre_len;
    logic [3:0] idx;
    logic [7:0] msg_left;
    logic [4:0] ttim;
    logic [4:0] tleft;
    logic [15:0] tsh;
    logic tchip;
    logic tdat;
    logic [2:0] trun;
    logic [15:0] tcrc;
    logic [3:0][7:0] hdr;
    logic [1:0][7:0] bdat;
    logic bwr;
    logic brd;
    logic [1:0] bcnt;
    logic tdone;
    logic tund;
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [4:0] rtim;
    rlcf_pkg::rlcf_rx_st_t rst;
    logic rmode;
    logic [15:0] rsh;
    logic [4:0] rcnt;
    logic [3:0] ridx;
    logic [7:0] rleft;
    logic [15:0] rcrc;
    logic [7:0] rhi;
    logic rerr;
    logic raddr;
    logic [7:0] rdat;
    logic rvld;
    logic rdone;
    logic rok;
  } rlcf_top_state_t;

  rlcf_top_state_t state_r;
  rlcf_top_state_t state_nxt;

  logic [7:0] tx_byte;
  logic [11:0] tx_sym;
  logic [7:0] rx_sym_byte;
  logic rx_sym_err;
  logic [15:0] rx_word;
  logic rx_samp;

  // Address trimmed to the selected width
  function automatic logic [7:0] addr_fit(input logic wide, input logic [7:0] a);
    return wide ? a : {4'h0, a[3:0]};
  endfunction

  // Manchester chips, most significant bit first
  function automatic logic [15:0] manch_enc(input logic [7:0] b);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      w[2 * i +: 2] = {b[i], ~b[i]};
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Symbol coder pair
  // ----------------------------------------------------------------
  assign rx_word = {state_r.rsh[14:0], state_r.lvl};

  rlcf_symtab u_symtab (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .enc_byte_in(tx_byte),
    .enc_word_out(tx_sym),
    .dec_word_in(rx_word[11:0]),
    .dec_byte_out(rx_sym_byte),
    .dec_err_out(rx_sym_err)
  );

  // Byte offered to the coder for the next unit
  always_comb begin
    case (state_r.tst)
      rlcf_pkg::T_HDR: tx_byte = state_r.hdr[state_r.idx[1:0]];
      rlcf_pkg::T_MSG: tx_byte = state_r.bdat[state_r.brd];
      rlcf_pkg::T_CRC: tx_byte = state_r.idx[0] ? ~state_r.tcrc[7:0] : ~state_r.tcrc[15:8];
      default: tx_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ld;
    logic emit;
    logic pop;
    logic push;
    logic [15:0] ldv;
    logic [4:0] ldn;
    logic [15:0] coded;
    logic [7:0] rb;
    logic bad;
    ld = 1'b0;
    emit = 1'b0;
    pop = 1'b0;
    push = tx_valid_in && (state_r.bcnt != rlcf_pkg::BUF_DEPTH);
    ldv = 16'h0000;
    ldn = rlcf_pkg::RAW_CHIPS;
    coded = state_r.tmode ? {tx_sym, 4'h0} : manch_enc(tx_byte);
    rb = 8'h00;
    bad = 1'b0;
    rx_samp = 1'b0;
    state_nxt = state_r;
    state_nxt.tdone = 1'b0;
    state_nxt.rvld = 1'b0;
    state_nxt.rdone = 1'b0;
    // Transmit sequencer, one chip per chip period
    if (state_r.tst == rlcf_pkg::T_IDLE) begin
      if (tx_start_in) begin
        state_nxt.tst = rlcf_pkg::T_PRE;
        state_nxt.tmode = mode_sel_in;
        state_nxt.pre_len = (preamble_len_in == 4'h0) ? rlcf_pkg::PRE_DEF : preamble_len_in;
        state_nxt.idx = 4'h0;
        state_nxt.ttim = 5'h00;
        state_nxt.tleft = 5'h00;
        state_nxt.hdr = {tx_size_in, tx_num_in, addr_fit(addr_wide_in, tx_src_in),
          addr_fit(addr_wide_in, tx_dst_in)};
        state_nxt.tcrc = rlcf_pkg::CRC_INIT;
        state_nxt.tund = 1'b0;
      end
    end else if (state_r.ttim != 5'h00) begin
      state_nxt.ttim = state_r.ttim - 5'h01;
    end else begin
      state_nxt.ttim = rlcf_pkg::CHIP_LAST;
      if (state_r.tleft != 5'h00) begin
        emit = 1'b1;
        state_nxt.tchip = state_r.tsh[15];
        state_nxt.tsh = {state_r.tsh[14:0], 1'b0};
        state_nxt.tleft = state_r.tleft - 5'h01;
      end else begin
        case (state_r.tst)
          rlcf_pkg::T_PRE: begin
            ld = 1'b1;
            ldv = {rlcf_pkg::PRE_BYTE, 8'h00};
            state_nxt.idx = state_r.idx + 4'h1;
            if (state_r.idx == state_r.pre_len - 4'h1) begin
              state_nxt.tst = rlcf_pkg::T_START;
              state_nxt.idx = 4'h0;
            end
          end
          rlcf_pkg::T_START: begin
            ld = 1'b1;
            ldv = {rlcf_pkg::START_PAT, 4'h0};
            ldn = rlcf_pkg::START_LEN;
            state_nxt.tst = rlcf_pkg::T_HDR;
          end
          rlcf_pkg::T_HDR: begin
            ld = 1'b1;
            state_nxt.idx = state_r.idx + 4'h1;
            if (state_r.idx == rlcf_pkg::HDR_LAST) begin
              state_nxt.idx = 4'h0;
              state_nxt.msg_left = state_r.hdr[3];
              state_nxt.tst = (state_r.hdr[3] == 8'h00) ? rlcf_pkg::T_CRC : rlcf_pkg::T_MSG;
            end
          end
          rlcf_pkg::T_MSG: begin
            if (state_r.bcnt != 2'h0) begin
              ld = 1'b1;
              pop = 1'b1;
              state_nxt.msg_left = state_r.msg_left - 8'h01;
              if (state_r.msg_left == 8'h01) begin
                state_nxt.tst = rlcf_pkg::T_CRC;
              end
            end else begin
              state_nxt.tund = 1'b1;
              state_nxt.ttim = 5'h00;
            end
          end
          rlcf_pkg::T_CRC: begin
            ld = 1'b1;
            state_nxt.idx = state_r.idx + 4'h1;
            if (state_r.idx[0]) begin
              state_nxt.tst = rlcf_pkg::T_FIN;
            end
          end
          default: begin
            state_nxt.tchip = 1'b0;
            state_nxt.tdat = 1'b0;
            state_nxt.tst = rlcf_pkg::T_IDLE;
            state_nxt.tdone = 1'b1;
          end
        endcase
        // Coded units replace the raw chip pattern
        if (ld && state_r.tst inside {rlcf_pkg::T_HDR, rlcf_pkg::T_MSG, rlcf_pkg::T_CRC}) begin
          ldv = coded;
          ldn = state_r.tmode ? rlcf_pkg::SYM_CHIPS : rlcf_pkg::MAN_CHIPS;
          if (state_r.tst != rlcf_pkg::T_CRC) begin
            state_nxt.tcrc = rlcf_pkg::crc_step(state_r.tcrc, tx_byte);
          end
        end
        if (ld) begin
          emit = 1'b1;
          state_nxt.tdat = state_r.tst inside {rlcf_pkg::T_HDR, rlcf_pkg::T_MSG, rlcf_pkg::T_CRC};
          state_nxt.tchip = ldv[15];
          state_nxt.tsh = {ldv[14:0], 1'b0};
          state_nxt.tleft = ldn - 5'h01;
        end
      end
    end
    // Run length of the line level
    if (emit) begin
      if (state_nxt.tchip != state_r.tchip) begin
        state_nxt.trun = 3'h1;
      end else if (state_r.trun != rlcf_pkg::RUN_MAX) begin
        state_nxt.trun = state_r.trun + 3'h1;
      end
    end
    // Two-entry transmit buffer
    if (push) begin
      state_nxt.bdat[state_r.bwr] = tx_data_in;
      state_nxt.bwr = ~state_r.bwr;
    end
    if (pop) begin
      state_nxt.brd = ~state_r.brd;
    end
    state_nxt.bcnt = state_r.bcnt + {1'b0, push} - {1'b0, pop};
    // Receive pin synchroniser, change taken when stages two and three agree
    state_nxt.s1 = rx_chip_in;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    if (state_r.s2 == state_r.s3) begin
      state_nxt.lvl = state_r.s3;
    end
    // Chip timing, re-centred on every line edge
    if (state_r.s2 == state_r.s3 && state_r.s3 != state_r.lvl) begin
      state_nxt.rtim = rlcf_pkg::CHIP_HALF;
    end else if (state_r.rtim != 5'h00) begin
      state_nxt.rtim = state_r.rtim - 5'h01;
    end else begin
      state_nxt.rtim = rlcf_pkg::CHIP_LAST;
      rx_samp = 1'b1;
    end
    // Receive framer
    if (rx_samp) begin
      state_nxt.rsh = rx_word;
      if (state_r.rst == rlcf_pkg::R_HUNT) begin
        if (rx_word[11:0] == rlcf_pkg::START_PAT) begin
          state_nxt.rst = rlcf_pkg::R_DATA;
          state_nxt.rmode = mode_sel_in;
          state_nxt.rcnt = 5'h00;
          state_nxt.ridx = 4'h0;
          state_nxt.rcrc = rlcf_pkg::CRC_INIT;
          state_nxt.rerr = 1'b0;
          state_nxt.raddr = 1'b0;
        end
      end else begin
        state_nxt.rcnt = state_r.rcnt + 5'h01;
        if (state_nxt.rcnt == (state_r.rmode ? rlcf_pkg::SYM_CHIPS : rlcf_pkg::MAN_CHIPS)) begin
          state_nxt.rcnt = 5'h00;
          if (state_r.rmode) begin
            rb = rx_sym_byte;
            bad = rx_sym_err;
          end else begin
            for (int i = 0; i < 8; i++) begin
              rb[i] = rx_word[2 * i + 1];
              bad = bad | (rx_word[2 * i + 1] == rx_word[2 * i]);
            end
          end
          state_nxt.rerr = state_r.rerr | bad;
          if (state_r.ridx < rlcf_pkg::RX_CRC_HI) begin
            state_nxt.rcrc = rlcf_pkg::crc_step(state_r.rcrc, rb);
            state_nxt.rdat = rb;
            state_nxt.rvld = 1'b1;
          end
          case (state_r.ridx)
            4'h0: begin
              state_nxt.raddr = (addr_fit(addr_wide_in, rb) == addr_fit(addr_wide_in,
                local_addr_in)) || (addr_wide_in ? rb == rlcf_pkg::BCAST8 :
                rb[3:0] == rlcf_pkg::BCAST4);
              state_nxt.ridx = 4'h1;
            end
            rlcf_pkg::HDR_LAST: begin
              state_nxt.rleft = rb;
              state_nxt.ridx = (rb == 8'h00) ? rlcf_pkg::RX_CRC_HI : rlcf_pkg::RX_MSG;
            end
            rlcf_pkg::RX_MSG: begin
              state_nxt.rleft = state_r.rleft - 8'h01;
              if (state_r.rleft == 8'h01) begin
                state_nxt.ridx = rlcf_pkg::RX_CRC_HI;
              end
            end
            rlcf_pkg::RX_CRC_HI: begin
              state_nxt.rhi = rb;
              state_nxt.ridx = rlcf_pkg::RX_CRC_LO;
            end
            rlcf_pkg::RX_CRC_LO: begin
              state_nxt.rok = (~state_r.rcrc == {state_r.rhi, rb});
              state_nxt.rdone = 1'b1;
              state_nxt.rst = rlcf_pkg::R_HUNT;
            end
            default: state_nxt.ridx = state_r.ridx + 4'h1;
          endcase
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_ready_out = state_r.bcnt != rlcf_pkg::BUF_DEPTH;
  assign tx_chip_out = state_r.tchip;
  assign tx_busy_out = state_r.tst != rlcf_pkg::T_IDLE;
  assign tx_done_out = state_r.tdone;
  assign tx_underrun_out = state_r.tund;
  assign rx_data_out = state_r.rdat;
  assign rx_valid_out = state_r.rvld;
  assign rx_busy_out = state_r.rst != rlcf_pkg::R_HUNT;
  assign rx_done_out = state_r.rdone;
  assign rx_crc_ok_out = state_r.rok;
  assign rx_code_err_out = state_r.rerr;
  assign rx_addr_ok_out = state_r.raddr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_manch_pair: assert property (state_r.ttim == 5'h00 && state_r.tleft[0] &&
    state_r.tdat && !state_r.tmode |=> tx_chip_out == !$past(tx_chip_out))
    else $error("Manchester pair not complementary");
  a_manch_run: assert property (tx_busy_out && !state_r.tmode |-> state_r.trun <= 3'h2)
    else $error("Manchester run over two chips");
  a_sym_run: assert property (tx_busy_out && state_r.tmode |-> state_r.trun <= 3'h4)
    else $error("symbol run over four bits");
  a_preamble_alt: assert property (state_r.ttim == 5'h00 && state_r.tleft != 5'h00 &&
    state_r.tst inside {rlcf_pkg::T_PRE, rlcf_pkg::T_START} |=> $changed(tx_chip_out))
    else $error("preamble not alternating");
  a_pre_len: assert property ($rose(state_r.tst == rlcf_pkg::T_START) |->
    $past(state_r.idx) == state_r.pre_len - 4'h1) else $error("preamble length wrong");
  a_field_order: assert property ($changed(state_r.tst) |->
    (state_r.tst == rlcf_pkg::T_PRE && $past(state_r.tst) == rlcf_pkg::T_IDLE) ||
    (state_r.tst == rlcf_pkg::T_START && $past(state_r.tst) == rlcf_pkg::T_PRE) ||
    (state_r.tst == rlcf_pkg::T_HDR && $past(state_r.tst) == rlcf_pkg::T_START) ||
    (state_r.tst == rlcf_pkg::T_MSG && $past(state_r.tst) == rlcf_pkg::T_HDR) ||
    (state_r.tst == rlcf_pkg::T_CRC && $past(state_r.tst) inside {rlcf_pkg::T_HDR,
    rlcf_pkg::T_MSG}) || (state_r.tst == rlcf_pkg::T_FIN && $past(state_r.tst) ==
    rlcf_pkg::T_CRC) || (state_r.tst == rlcf_pkg::T_IDLE && $past(state_r.tst) ==
    rlcf_pkg::T_FIN)) else $error("field order broken");
  a_start_detect: assert property (rx_samp && !rx_busy_out &&
    rx_word[11:0] == rlcf_pkg::START_PAT |=> rx_busy_out) else $error("start pattern missed");
  a_mode_fixed: assert property (tx_busy_out && $past(tx_busy_out) |->
    $stable(state_r.tmode)) else $error("mode changed inside packet");
  a_done_idle: assert property (tx_done_out |-> !tx_busy_out && !tx_chip_out)
    else $error("done while busy");

  c_manch_packet: cover property (tx_done_out && !state_r.tmode);
  c_sym_packet: cover property (tx_done_out && state_r.tmode);
  c_rx_good: cover property (rx_done_out && rx_crc_ok_out && !rx_code_err_out);
  c_buf_full: cover property (!tx_ready_out && tx_valid_in);

endmodule

// ### sim/radio_line_coder_framer_test.sv
// Self-checking bench: packets coded, looped through a radio model, decoded.
// Assumes the design package is compiled first and one 200 MHz clock.
module radio_line_coder_framer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, sys_rst_in, mode_sel_in, addr_wide_in, tx_start_in, tx_valid_in;
  logic [3:0] preamble_len_in, lag;
  logic [7:0] local_addr_in, tx_dst_in, tx_src_in, tx_num_in, tx_size_in, tx_data_in;
  logic tx_ready_out, tx_chip_out, tx_busy_out, tx_done_out, tx_underrun_out, rx_chip_in;
  logic [7:0] rx_data_out;
  logic rx_valid_out, rx_busy_out, rx_done_out, rx_crc_ok_out, rx_code_err_out, rx_addr_ok_out;
  int err_count = 0, tests_run = 0, flip_at = 0, flip_len = 0, run = 1, run_lim = 40, dn = 0;
  logic last_chip = 1'b0;
  logic ch[512];

  rlcf_top i_dut (.*);
  rlcf_radio_model i_radio (
    .clock_in(clock_in),
    .tx_chip_in(tx_chip_out),
    .lag_in(lag),
    .flip_at_in(flip_at),
    .flip_len_in(flip_len),
    .rx_chip_out(rx_chip_in)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input bit ok, input string s);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Complemented reflected check over six bytes
  function automatic logic [15:0] frame_check_field(input logic [7:0] b[6]);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 48; i++) c = (c[0] ^ b[i / 8][i % 8]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction

  // Longest run of equal chips while a packet is on the line
  always @(posedge clock_in) begin
    if (tx_busy_out === 1'b1 && tx_chip_out === last_chip) run = run + 1;
    else run = 1;
    last_chip = tx_chip_out;
    if (run > run_lim) chk(1'b0, "run too long");
    if (tx_done_out === 1'b1) dn = dn + 1;
  end

  // ----------------------------------------------------------------
  // One packet out and back, judged on the wire and at the receiver
  // ----------------------------------------------------------------
  task automatic pkt(input logic m, w, input logic [7:0] dst, input logic [3:0] pl,
                     input int fa, fl, input logic [7:0] fx, input logic ok, er, ad);
    logic [7:0] hb[6];
    logic [7:0] got[$];
    logic [15:0] c;
    logic [11:0] sw;
    int n, p, u, k, q, o, d;
    n = 0;
    d = dn;
    p = (pl == 0 ? 4 : pl) * 8;
    u = m ? 12 : 16;
    hb = '{w ? dst : {4'h0, dst[3:0]}, w ? 8'h5A : 8'h0A, 8'h07, 8'h02, 8'hC3, 8'h3C};
    // Quiet line first, so the model's frame timer restarts
    repeat (120) @(negedge clock_in);
    {mode_sel_in, addr_wide_in, preamble_len_in, tx_dst_in} = {m, w, pl, dst};
    {tx_src_in, tx_num_in, tx_size_in} = {hb[1], hb[2], hb[3]};
    flip_at = fa;
    flip_len = fl;
    run_lim = (m ? 4 : 2) * rlcf_pkg::CHIP_CYC;
    tx_valid_in = 1'b1;
    tx_data_in = hb[4];
    @(negedge clock_in);
    tx_data_in = hb[5];
    @(negedge clock_in);
    tx_valid_in = 1'b0;
    chk(tx_ready_out === 1'b0, "full buffer still ready");
    tx_start_in = 1'b1;
    @(negedge clock_in);
    tx_start_in = 1'b0;
    fork
      begin
        repeat (11) @(negedge clock_in);
        while (tx_busy_out === 1'b1 && n < 512) begin
          ch[n] = tx_chip_out;
          n++;
          repeat (20) @(negedge clock_in);
        end
      end
      begin
        q = 0;
        while (rx_busy_out !== 1'b1 && q < 5000) begin
          @(negedge clock_in);
          q++;
        end
        tx_start_in = 1'b1;
        mode_sel_in = ~m;
        @(negedge clock_in);
        tx_start_in = 1'b0;
        repeat (200) @(negedge clock_in);
        mode_sel_in = m;
      end
      begin
        k = 0;
        while (rx_done_out !== 1'b1 && k < 9000) begin
          @(posedge clock_in);
          #1;
          if (rx_valid_out === 1'b1) got.push_back(rx_data_out);
          k++;
        end
      end
    join
    chk(k < 9000, "receive timeout");
    chk(q < 5000, "start pattern never seen");
    if (k >= 9000 || q >= 5000 || n >= 512) end_of_test();
    chk(n == p + 12 + 8 * u, "chip count");
    for (int i = 0; i < p; i++) chk(ch[i] === ~i[0], "preamble chip");
    for (int i = 0; i < 12; i++) chk(ch[p + i] === rlcf_pkg::START_PAT[11 - i], "start chip");
    if (m == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        chk(ch[p + 12 + 2 * i] === hb[0][7 - i], "first chip of bit");
        chk(ch[p + 13 + 2 * i] === ~hb[0][7 - i], "second chip of bit");
      end
      for (int i = 0; i < 16; i++) c[15 - i] = ch[n - 32 + 2 * i];
      chk(c === frame_check_field(hb), "check field on line");
    end else begin
      sw = {rlcf_pkg::SYM_TAB[hb[0][7:4]], rlcf_pkg::SYM_TAB[hb[0][3:0]]};
      for (int i = 0; i < 12; i++) chk(ch[p + 12 + i] === sw[11 - i], "symbol chip");
      for (int j = 0; j < 8; j++) begin
        o = 0;
        for (int i = 0; i < 12; i++) o += (ch[p + 12 + 12 * j + i] === 1'b1);
        chk(o == 6, "symbol not balanced");
      end
    end
    chk(got.size() == 6, "received byte count");
    if (!er && got.size() == 6) begin
      for (int i = 0; i < 6; i++) chk(got[i] === (hb[i] ^ (i == 4 ? fx : 8'h00)), "rx byte");
      chk(rx_crc_ok_out === ok, "check verdict");
    end
    chk(rx_code_err_out === er, "code error flag");
    chk(rx_addr_ok_out === ad, "address match");
    chk(tx_ready_out === 1'b1 && tx_underrun_out === 1'b0, "buffer not drained");
    chk(tx_busy_out === 1'b0 && rx_busy_out === 1'b0, "link not idle");
    chk(dn == d + 1, "one done pulse per packet");
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  initial begin
    {sys_rst_in, mode_sel_in, addr_wide_in, tx_start_in, tx_valid_in} = 5'h10;
    {preamble_len_in, lag, local_addr_in, tx_data_in} = {4'h0, 4'h1, 8'h21, 8'h00};
    {tx_dst_in, tx_src_in, tx_num_in, tx_size_in} = 32'h0000_0000;
    repeat (5) @(negedge clock_in);
    chk(tx_ready_out === 1'b1 && tx_busy_out === 1'b0 && tx_chip_out === 1'b0, "reset state");
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    pkt(0, 1, 8'h21, 4'h0, 0, 0, 8'h00, 1, 0, 1);
    lag = 4'h9;
    pkt(1, 0, 8'hFF, 4'h6, 0, 0, 8'h00, 1, 0, 1);
    pkt(0, 1, 8'h44, 4'h3, 2000, 40, 8'h80, 0, 0, 0);
    lag = 4'h2;
    pkt(0, 1, 8'h21, 4'h0, 2260, 20, 8'h00, 0, 1, 1);
    pkt(1, 1, 8'h21, 4'h0, 1880, 20, 8'h00, 0, 1, 1);
    end_of_test();
  end
endmodule

// ### sim/rlcf_radio_model.sv
// Radio front end model: loops transmit chips back to the receive pin.
// Assumes one clock; inverts the chip line for a commanded span of clock cycles to inject line faults.
module rlcf_radio_model (
  input wire logic clock_in,
  input wire logic tx_chip_in,
  input wire logic [3:0] lag_in,
  input wire logic signed [31:0] flip_at_in,
  input wire logic signed [31:0] flip_len_in,
  output logic rx_chip_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] dly_r = 16'h0000;
  int t_r = 0;
  int idle_r = 0;
  // Air delay line, frame timer restarts after a long quiet line
  always_ff @(posedge clock_in) begin
    dly_r <= {dly_r[14:0], tx_chip_in ^ (t_r >= flip_at_in && t_r < flip_at_in + flip_len_in)};
    idle_r <= tx_chip_in ? 0 : idle_r + 1;
    t_r <= (idle_r > 100 && !tx_chip_in) ? 0 : (t_r != 0 || tx_chip_in) ? t_r + 1 : 0;
  end
  // Slow or prompt slicer output by tap choice
  assign rx_chip_out = dly_r[lag_in];
endmodule
